// [mtc_pkg.sv]
// Package for the measure/trigger mode control block.
// Assumes a single pclk domain and APB register access.
package mtc_pkg;
    typedef enum logic [2:0] {
        MTC_FREE_RUN, MTC_FILT_MEAS, MTC_SETL_MEAS,
        MTC_PLAIN_TRIG, MTC_FILT_TRIG, MTC_SETL_TRIG
    } mtc_mode_e;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [7:0] MTC_CTRL_OFS = 8'h00;
    localparam logic [7:0] MTC_CMD_OFS = 8'h04;
    localparam logic [7:0] MTC_FILT_OFS = 8'h08;
    localparam logic [7:0] MTC_STAT_OFS = 8'h0C;
    localparam logic [7:0] MTC_DATA_OFS = 8'h10;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int MTC_MODE_LSB = 0;
    localparam int MTC_MODE_MSB = 2;
    localparam int MTC_REMOTE_BIT = 3;
    localparam int MTC_CMD_TRIG_BIT = 0;
    localparam int MTC_CMD_LOCAL_BIT = 1;
    localparam int MTC_CMD_CALX_BIT = 2;
    localparam int MTC_ST_WAIT_BIT = 3;
    localparam int MTC_ST_DASH_BIT = 4;
    localparam int MTC_ST_TWAIT_BIT = 5;
    localparam int MTC_ST_VALID_BIT = 6;
    // ----------------------------------------
    // Reset values and timing
    // ----------------------------------------
    localparam int MTC_DATA_W = 24;
    localparam int MTC_TC_W = 32;
    localparam int MTC_CLK_MHZ = 125;
    localparam int MTC_FILT_MS_DEF = 1000;
    localparam int MTC_CYC_PER_MS = MTC_CLK_MHZ * 1000;
    localparam logic [31:0] MTC_FILT_RST =
        32'(MTC_FILT_MS_DEF * MTC_CYC_PER_MS);
    localparam logic [31:0] MTC_ZERO = 32'h0000_0000;
endpackage : mtc_pkg

// [mtc_holdoff.sv]
// Hold-off timer: counts one or two filter time constants.
// Assumes restart pulses come from the mode controller.
`timescale 1ns/1ns
module mtc_holdoff #(
    parameter int TC_W = 32
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // Control
    input wire logic start,
    input wire logic two_tc,
    input wire logic cancel,
    input wire logic [TC_W-1:0] tc_cycles,
    // Status
    output logic busy
);
    import mtc_pkg::*;
    logic [TC_W:0] cnt_reg;
    logic busy_reg;
    wire [TC_W:0] load_val = two_tc ? {tc_cycles, 1'b0}
                                    : {1'b0, tc_cycles};
    wire done = (cnt_reg <= (TC_W+1)'(1));
    assign busy = busy_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end else if (clk_en) begin
            // Restart always wins so a new step reloads the count
            if (start) begin
                cnt_reg <= load_val;
                busy_reg <= 1'b1;
            end else if (cancel || (busy_reg && done)) begin
                cnt_reg <= '0;
                busy_reg <= 1'b0;
            end else if (busy_reg) begin
                cnt_reg <= cnt_reg - (TC_W+1)'(1);
            end
        end
    end
endmodule : mtc_holdoff

// [mtc_apb_regs.sv]
// APB slave register file for the mode controller.
// Assumes zero-wait APB; unmapped reads return zero, no error.
`timescale 1ns/1ns
module mtc_apb_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Register fields
    output logic [2:0] mode_wr,
    output logic mode_wr_stb,
    output logic remote,
    output logic trig_stb,
    output logic local_stb,
    output logic calx_stb,
    output logic [31:0] filt_cycles,
    input wire logic [31:0] stat_word,
    input wire logic [31:0] data_word
);
    import mtc_pkg::*;
    logic [3:0] ctrl_reg;
    logic [31:0] filt_reg;
    wire acc = psel && penable && clk_en;
    wire wr = acc && pwrite;
    wire sel_ctrl = (paddr == MTC_CTRL_OFS);
    wire sel_cmd = (paddr == MTC_CMD_OFS);
    wire sel_filt = (paddr == MTC_FILT_OFS);
    wire sel_stat = (paddr == MTC_STAT_OFS);
    wire sel_data = (paddr == MTC_DATA_OFS);
    wire cmd_wr = wr && sel_cmd;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign mode_wr = pwdata[MTC_MODE_MSB:MTC_MODE_LSB];
    assign mode_wr_stb = wr && sel_ctrl;
    assign remote = ctrl_reg[MTC_REMOTE_BIT];
    assign trig_stb = cmd_wr && pwdata[MTC_CMD_TRIG_BIT];
    assign local_stb = cmd_wr && pwdata[MTC_CMD_LOCAL_BIT];
    assign calx_stb = cmd_wr && pwdata[MTC_CMD_CALX_BIT];
    assign filt_cycles = filt_reg;
    always_comb begin
        prdata = MTC_ZERO;
        if (sel_ctrl) prdata = {28'h0000000, ctrl_reg};
        if (sel_filt) prdata = filt_reg;
        if (sel_stat) prdata = stat_word;
        if (sel_data) prdata = data_word;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= 4'h0;
            filt_reg <= MTC_FILT_RST;
        end else begin
            if (wr && sel_ctrl) ctrl_reg <= pwdata[3:0];
            // Return-to-local drops remote control
            else if (local_stb) ctrl_reg[MTC_REMOTE_BIT] <= 1'b0;
            if (wr && sel_filt) filt_reg <= pwdata;
        end
    end
endmodule : mtc_apb_regs

// [mtc_mode_ctrl.sv]
// Top of the measure/trigger mode controller.
// Assumes measurement samples, step and range flags arrive on pclk.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ns
// Contract
// - Bus modes selectable only under remote
// - Local control forces free-run mode
// - Measure modes self-trigger; triggered need trigger
// - Free-run at reset, local, calibration exit
// - Filtered measure: dashes for one constant
// - Settled measure: dashes for two constants
// - Plain triggered: wait, latch on trigger
// - Filtered triggered: restart, wait one constant
// - Settled triggered: restart, wait two constants
// - Before first trigger show latest reading (code: filtered/settled triggered only, plain keeps old value)
// - Bus and device triggers both count
// - Hold-off follows configured filter time
module mtc_mode_ctrl #(
    parameter int DATA_W = mtc_pkg::MTC_DATA_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Measurement path
    input wire logic [DATA_W-1:0] meas_data,
    input wire logic meas_valid,
    input wire logic power_step,
    input wire logic range_change,
    input wire logic bus_get_trigger,
    // Display
    output logic [DATA_W-1:0] disp_data,
    output logic disp_dashes,
    output logic disp_trig_wait,
    output logic filter_restart,
    output logic [2:0] active_mode
);
    import mtc_pkg::*;
    // ----------------------------------------
    // Register interface
    // ----------------------------------------
    logic [2:0] mode_wr;
    logic mode_wr_stb, remote, trig_stb, local_stb, calx_stb;
    logic [31:0] filt_cycles, stat_word, data_word;
    mtc_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .mode_wr(mode_wr),
        .mode_wr_stb(mode_wr_stb),
        .remote(remote),
        .trig_stb(trig_stb),
        .local_stb(local_stb),
        .calx_stb(calx_stb),
        .filt_cycles(filt_cycles),
        .stat_word(stat_word),
        .data_word(data_word)
    );
    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    function automatic logic is_trig_mode(input mtc_mode_e m);
        is_trig_mode = (m == MTC_PLAIN_TRIG) || (m == MTC_FILT_TRIG)
                    || (m == MTC_SETL_TRIG);
    endfunction : is_trig_mode
    function automatic logic is_settled(input mtc_mode_e m);
        is_settled = (m == MTC_SETL_MEAS) || (m == MTC_SETL_TRIG);
    endfunction : is_settled
    mtc_mode_e sel_reg, sel_next;
    mtc_mode_e mode_now;
    wire mode_code_ok = (mode_wr <= 3'(MTC_SETL_TRIG));
    wire mode_take = mode_wr_stb && remote && mode_code_ok;
    // local or calibration exit resets mode
    wire mode_back = local_stb || calx_stb;
    always_comb begin
        sel_next = sel_reg;
        if (mode_back) sel_next = MTC_FREE_RUN;
        else if (mode_take) sel_next = mtc_mode_e'(mode_wr);
    end
    assign mode_now = remote ? sel_reg : MTC_FREE_RUN;
    assign active_mode = mode_now;
    // ----------------------------------------
    // Trigger and hold-off events
    // ----------------------------------------
    // either trigger source counts
    wire trig_any = (trig_stb || bus_get_trigger) && remote;
    wire mode_chg = mode_back || mode_take;
    wire trig_mode = is_trig_mode(mode_now);
    wire filt_meas = (mode_now == MTC_FILT_MEAS)
                  || (mode_now == MTC_SETL_MEAS);
    wire filt_trig = (mode_now == MTC_FILT_TRIG)
                  || (mode_now == MTC_SETL_TRIG);
    // step or range change in measure modes
    wire step_evt = filt_meas && (power_step || range_change);
    wire trig_restart = filt_trig && trig_any;
    // Mode change wins, so no restart pulse without a hold-off
    wire hold_start = (step_evt || trig_restart) && !mode_chg;
    logic busy;
    mtc_holdoff #(.TC_W(MTC_TC_W)) u_hold (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .start(hold_start),
        .two_tc(is_settled(mode_now)),
        .cancel(mode_chg),
        .tc_cycles(filt_cycles),
        .busy(busy)
    );
    // ----------------------------------------
    // Display state
    // ----------------------------------------
    logic [DATA_W-1:0] last_reg, disp_reg;
    logic armed_reg, held_reg, fresh_reg, restart_reg;
    wire hold_done = armed_reg && !busy && fresh_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= MTC_FREE_RUN;
            last_reg <= '0;
            disp_reg <= '0;
            armed_reg <= 1'b0;
            held_reg <= 1'b0;
            fresh_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else if (clk_en) begin
            sel_reg <= sel_next;
            restart_reg <= hold_start;
            if (meas_valid) last_reg <= meas_data;
            if (mode_chg) begin
                armed_reg <= 1'b0;
                held_reg <= 1'b0;
                fresh_reg <= 1'b0;
            end else if (trig_restart) begin
                armed_reg <= 1'b1;
                held_reg <= 1'b0;
                fresh_reg <= 1'b0;
            end else if (trig_any && mode_now == MTC_PLAIN_TRIG) begin
                disp_reg <= meas_valid ? meas_data : last_reg;
                held_reg <= 1'b1;
            end else if (armed_reg) begin
                // Only samples after restart count as filtered
                if (busy && meas_valid) fresh_reg <= 1'b1;
                if (hold_done) begin
                    disp_reg <= last_reg;
                    held_reg <= 1'b1;
                    armed_reg <= 1'b0;
                end
            end
            if (!trig_mode && meas_valid) disp_reg <= meas_data;
            if (filt_trig && !armed_reg && !held_reg && meas_valid)
                disp_reg <= meas_data;
        end
    end
    // ----------------------------------------
    // Outputs and status
    // ----------------------------------------
    assign disp_data = disp_reg;
    assign filter_restart = restart_reg;
    assign disp_dashes = filt_meas && busy;
    // trig-wait until trigger or filter done
    assign disp_trig_wait = ((mode_now == MTC_PLAIN_TRIG) && !held_reg)
                         || (filt_trig && armed_reg);
    assign stat_word = {25'h0000000, held_reg, disp_trig_wait,
                        disp_dashes, 1'b0, mode_now};
    assign data_word = 32'(disp_reg);
endmodule : mtc_mode_ctrl

// [mtc_checker.sv]
// Port checker for the measure/trigger mode controller.
// Assumes binding to mtc_mode_ctrl on the single pclk domain.
`timescale 1ns/1ns
module mtc_checker #(
    parameter int DATA_W = 24
) (
    // Clock, reset and bus
    input wire logic pclk, presetn, clk_en, psel, penable, pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic pready, pslverr,
    // Measurement and display
    input wire logic [DATA_W-1:0] meas_data, disp_data,
    input wire logic meas_valid, power_step, range_change,
    input wire logic bus_get_trigger, disp_dashes, disp_trig_wait,
    input wire logic filter_restart,
    input wire logic [2:0] active_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_access_ready: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    a_no_error: assert property (psel |-> !pslverr)
        else $error("pslverr raised");
    a_mode_legal: assert property (active_mode <= 3'h5)
        else $error("active mode out of range");
    a_dash_mode: assert property (
        disp_dashes |-> active_mode inside {3'h1, 3'h2})
        else $error("dashes outside measure modes");
    a_wait_mode: assert property (disp_trig_wait |-> active_mode >= 3'h3)
        else $error("trigger wait outside triggered modes");
    // Only bus traffic or a trigger may move a held reading
    a_plain_hold: assert property (
        active_mode == 3'h3 && !psel && !bus_get_trigger |=> $stable(disp_data))
        else $error("held reading changed");
    a_restart_wait: assert property (
        filter_restart && active_mode >= 3'h4 |-> disp_trig_wait)
        else $error("restart without trigger wait");
    a_mode_hold: assert property (!psel |=> $stable(active_mode))
        else $error("mode changed without bus write");
    c_dash_end: cover property ($fell(disp_dashes));
    c_settled_done: cover property ($fell(disp_trig_wait) && active_mode == 3'h5);
    c_restart: cover property (filter_restart);
endmodule : mtc_checker

bind mtc_mode_ctrl mtc_checker #(.DATA_W(DATA_W)) mtc_checker_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_data(meas_data), .disp_data(disp_data), .meas_valid(meas_valid),
    .power_step(power_step), .range_change(range_change),
    .bus_get_trigger(bus_get_trigger), .disp_dashes(disp_dashes),
    .disp_trig_wait(disp_trig_wait), .filter_restart(filter_restart),
    .active_mode(active_mode));

// [mtc_bus_ctrl.sv]
// Model of the remote bus controller: APB master and bus trigger.
// Assumes the testbench calls its tasks one at a time.
`timescale 1ns/1ns
module mtc_bus_ctrl (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel, penable, pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Group execute trigger
    output logic get_trig
);
    initial begin
        {psel, penable, pwrite, get_trig} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data must not look like the last value
        pwdata <= ~d;
    endtask : xfer
    task automatic set_mode(input logic [2:0] m);
        logic [31:0] q;
        xfer(1'b1, 8'h00, 32'h8, q);
        xfer(1'b1, 8'h00, {28'h0, 1'b1, m}, q);
    endtask : set_mode
    task automatic trig();
        @(posedge pclk);
        get_trig <= 1'b1;
        @(posedge pclk);
        get_trig <= 1'b0;
    endtask : trig
endmodule : mtc_bus_ctrl

// [tb.sv]
// Self-checking testbench for the mode controller.
// Assumes the bus controller model drives APB and the bus trigger.
`timescale 1ns/1ns
module tb;
    import mtc_pkg::*;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic meas_valid, power_step, range_change, get_trig;
    logic [23:0] meas_data, disp_data, sample;
    logic disp_dashes, disp_trig_wait, filter_restart;
    logic [2:0] active_mode;
    int fails, samples_checked;
    mtc_mode_ctrl mtc_mode_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .meas_data(meas_data), .meas_valid(meas_valid),
        .power_step(power_step), .range_change(range_change),
        .bus_get_trigger(get_trig), .disp_data(disp_data),
        .disp_dashes(disp_dashes), .disp_trig_wait(disp_trig_wait),
        .filter_restart(filter_restart), .active_mode(active_mode));
    mtc_bus_ctrl mtc_bus_ctrl_inst (.pclk(pclk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .get_trig(get_trig));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        mtc_bus_ctrl_inst.xfer(1'b1, a, d, q);
    endtask : wr
    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle
    task automatic fire(input int ev);
        if (ev == 3) wr(MTC_CMD_OFS, 32'h1);
        else if (ev == 2) mtc_bus_ctrl_inst.trig();
        else begin
            @(posedge pclk);
            if (ev == 0) power_step <= 1'b1;
            else range_change <= 1'b1;
            @(posedge pclk);
            power_step <= 1'b0;
            range_change <= 1'b0;
        end
    endtask : fire
    task automatic final_report();
        if (fails == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_local();
        settle(1);
        chk("mode", 32'h0, 32'(active_mode));
        chk("disp", 32'h0, 32'(disp_data));
        wr(MTC_CTRL_OFS, 32'h1);
        settle(1);
        chk("mode", 32'h0, 32'(active_mode));
        mtc_bus_ctrl_inst.set_mode(3'h2);
        mtc_bus_ctrl_inst.xfer(1'b0, MTC_STAT_OFS, 32'h0, q);
        chk("stat", 32'h2, q & 32'h7);
        mtc_bus_ctrl_inst.xfer(1'b0, 8'h20, 32'h0, q);
        chk("unmapped", 32'h0, q);
        mtc_bus_ctrl_inst.xfer(1'b0, MTC_FILT_OFS, 32'h0, q);
        chk("filt", MTC_FILT_RST, q);
        wr(MTC_CMD_OFS, 32'h2);
        wr(MTC_CTRL_OFS, 32'h9);
        settle(1);
        chk("mode", 32'h0, 32'(active_mode));
        mtc_bus_ctrl_inst.set_mode(3'h1);
        wr(MTC_CMD_OFS, 32'h4);
        settle(1);
        chk("mode", 32'h0, 32'(active_mode));
    endtask : t_local
    task automatic t_plain();
        mtc_bus_ctrl_inst.set_mode(3'h3);
        sample = 24'h00A5A5;
        settle(3);
        chk("twait", 32'h1, 32'(disp_trig_wait));
        fire(2);
        sample = 24'h005A5A;
        settle(4);
        chk("held", 32'h00A5A5, 32'(disp_data));
        fire(3);
        settle(2);
        chk("held", 32'h005A5A, 32'(disp_data));
        mtc_bus_ctrl_inst.xfer(1'b0, MTC_DATA_OFS, 32'h0, q);
        chk("data_reg", 32'h005A5A, q);
    endtask : t_plain
    task automatic t_span(input logic [2:0] m, input int f, input int k,
                          input int ev, input bit again);
        int n;
        n = 0;
        mtc_bus_ctrl_inst.set_mode(m);
        // New value only after the mode change, so tracking is tested
        sample = 24'(f * 3 + m);
        wr(MTC_FILT_OFS, 32'(f));
        settle(4);
        chk("twait", 32'h0, 32'(disp_trig_wait));
        if (m > 3'h3) chk("latest", 32'(sample), 32'(disp_data));
        fire(ev);
        if (again) begin
            settle(4);
            fire(ev);
        end
        // Held result must come from samples after the restart
        sample = ~sample;
        // Total high time, so start latency does not matter
        for (int i = 0; i < 60; i++) begin
            settle(1);
            if ((m < 3'h3) ? disp_dashes : disp_trig_wait) n++;
        end
        chk("span", 32'h1, 32'(n >= k * f - 1 && n <= k * f + 6));
        if (m > 3'h3) chk("data", 32'(sample), 32'(disp_data));
    endtask : t_span
    task automatic t_abort();
        mtc_bus_ctrl_inst.set_mode(3'h1);
        fire(0);
        settle(2);
        chk("dashes", 32'h1, 32'(disp_dashes));
        @(posedge pclk);
        clk_en <= 1'b0;
        settle(20);
        chk("frozen", 32'h1, 32'(disp_dashes));
        @(posedge pclk);
        clk_en <= 1'b1;
        wr(MTC_CTRL_OFS, 32'h9);
        settle(1);
        chk("dashes", 32'h0, 32'(disp_dashes));
    endtask : t_abort
    // ----------------------------------------
    // Clock, stimulus and sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        meas_valid <= ~meas_valid;
        meas_data <= sample;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report();
    end
    initial begin
        {presetn, meas_valid, power_step, range_change} = 4'h0;
        clk_en = 1'b1;
        sample = 24'h0;
        meas_data = 24'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_local();
        t_plain();
        t_span(3'h1, 8, 1, 0, 1'b0);
        t_span(3'h1, 16, 1, 1, 1'b0);
        t_span(3'h2, 8, 2, 0, 1'b0);
        t_span(3'h4, 8, 1, 3, 1'b0);
        t_span(3'h5, 8, 2, 2, 1'b0);
        t_span(3'h4, 8, 1, 2, 1'b1);
        t_abort();
        final_report();
    end
endmodule : tb
